/* File: bifd_pkg.sv */
// Package with the control-byte layouts, codes and register map of the decoder.
package bifd_pkg;
	// Operation codes.
	localparam logic [7:0] OP_CHECK = 8'h13;
	localparam logic [7:0] OP_INSERT = 8'h14;
	localparam logic [7:0] OP_STRIP = 8'h16;
	localparam logic [7:0] OP_UPDATE = 8'h15;
	// Common byte fields.
	localparam int CMN_SIZE_LO = 0;
	localparam int CMN_SEED_INV = 2;
	localparam int CMN_RES_INV = 3;
	// Source byte fields.
	localparam int SRC_REF_FIXED = 7;
	localparam int SRC_REF_NOCHK = 6;
	localparam int SRC_GRD_NOCHK = 5;
	localparam int SRC_APP_INCR = 4;
	localparam int SRC_AR_FDET = 3;
	localparam int SRC_APP_FDET = 2;
	localparam int SRC_ALL_FDET = 1;
	localparam int SRC_ALL_ERR = 0;
	// Destination byte fields.
	localparam int DST_REF_FIXED = 7;
	localparam int DST_REF_PASS = 6;
	localparam int DST_GRD_PASS = 5;
	localparam int DST_APP_INCR = 4;
	localparam int DST_APP_PASS = 3;
	// Block sizes in bytes.
	localparam logic [12:0] BLK_512 = 13'h0200;
	localparam logic [12:0] BLK_520 = 13'h0208;
	localparam logic [12:0] BLK_4096 = 13'h1000;
	localparam logic [12:0] BLK_4104 = 13'h1008;
	// Seeds.
	localparam logic [15:0] SEED_ZERO = 16'h0000;
	localparam logic [15:0] SEED_ONES = 16'hFFFF;
	// Status codes.
	localparam logic [7:0] ST_GUARD = 8'h01;
	localparam logic [7:0] ST_APP = 8'h02;
	localparam logic [7:0] ST_REF = 8'h04;
	localparam logic [7:0] ST_ALLF = 8'h08;
	// Register byte offsets.
	localparam logic [7:0] A_CTRL = 8'h00;
	localparam logic [7:0] A_OPER = 8'h04;
	localparam logic [7:0] A_DECODE = 8'h08;
	localparam logic [7:0] A_STATUS = 8'h0C;
	localparam logic [7:0] A_CRC = 8'h10;
endpackage : bifd_pkg

/* File: bifd_decode.sv */
// Decoder of block integrity field control bytes with an APB register file.
//
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/1ps

module bifd_decode (
	input wire logic pclk, // Engine clock.
	input wire logic presetn, // Asynchronous reset, active low.
	input wire logic psel, // APB select.
	input wire logic penable, // APB access phase.
	input wire logic pwrite, // APB write.
	input wire logic [7:0] paddr, // APB byte address.
	input wire logic [31:0] pwdata, // APB write data.
	output logic [31:0] prdata, // APB read data.
	output logic pready, // APB ready.
	output logic pslverr, // APB error for unmapped addresses.
	input wire logic blk_valid, // Datapath presents a block result.
	input wire logic [15:0] src_guard, // Guard field read from source.
	input wire logic [15:0] src_app, // Application tag from source.
	input wire logic [31:0] src_ref, // Reference tag from source.
	input wire logic [15:0] calc_crc, // Raw CRC computed over the block.
	input wire logic [15:0] exp_app, // Expected application tag.
	input wire logic [31:0] exp_ref, // Expected reference tag.
	input wire logic [15:0] gen_app, // Destination tag from seed and mask.
	input wire logic [31:0] gen_ref, // Destination tag from its seed.
	output logic [12:0] blk_bytes, // Protected block length.
	output logic [15:0] crc_seed, // Guard CRC start value.
	output logic src_ref_inc, // Expected reference tag steps per block.
	output logic src_app_inc, // Expected application tag steps per block.
	output logic dst_ref_inc, // Generated reference tag steps per block.
	output logic dst_app_inc, // Generated application tag steps per block.
	output logic res_valid, // Block result below is valid, one cycle.
	output logic [7:0] blk_status, // Integrity status code of the block.
	output logic [15:0] out_guard, // Guard written to destination.
	output logic [15:0] out_app, // Application tag written out.
	output logic [31:0] out_ref // Reference tag written out.
);
	logic [7:0] cmn_flags;
	logic [7:0] src_flags;
	logic [7:0] dst_flags;
	logic [7:0] op_code;
	logic [7:0] sticky_status;
	logic [15:0] last_crc;
	logic is_update;
	logic [15:0] final_crc;
	logic app_ones;
	logic ref_ones;
	logic grd_ones;
	logic fdet_ar;
	logic fdet_app;
	logic fdet_all;
	logic fdet;
	logic [7:0] next_status;
	logic wr_en;
	logic rd_en;
	logic addr_ok;

	// The slave answers in the first access cycle; no wait states.
	assign pready = 1'h1;
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && penable && !pwrite;
	assign addr_ok = (paddr == bifd_pkg::A_CTRL) ||
		(paddr == bifd_pkg::A_OPER) || (paddr == bifd_pkg::A_DECODE) ||
		(paddr == bifd_pkg::A_STATUS) || (paddr == bifd_pkg::A_CRC);
	assign pslverr = psel && penable && !addr_ok;

	// Control bytes as copied out of the descriptor by software.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmn_flags <= 8'h00;
			src_flags <= 8'h00;
			dst_flags <= 8'h00;
		end else if (wr_en && paddr == bifd_pkg::A_CTRL) begin
			cmn_flags <= pwdata[7:0];
			dst_flags <= pwdata[15:8];
			src_flags <= pwdata[23:16];
		end
	end

	// Operation code of the running descriptor.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			op_code <= 8'h00;
		end else if (wr_en && paddr == bifd_pkg::A_OPER) begin
			op_code <= pwdata[7:0];
		end
	end

	assign is_update = (op_code == bifd_pkg::OP_UPDATE);

	// Block size table; upper common bits are never looked at.
	always_comb begin
		case (cmn_flags[bifd_pkg::CMN_SIZE_LO +: 2])
			2'h0: blk_bytes = bifd_pkg::BLK_512;
			2'h1: blk_bytes = bifd_pkg::BLK_520;
			2'h2: blk_bytes = bifd_pkg::BLK_4096;
			2'h3: blk_bytes = bifd_pkg::BLK_4104;
			default: blk_bytes = bifd_pkg::BLK_512;
		endcase
	end

	// Seed and final inversion.
	assign crc_seed = cmn_flags[bifd_pkg::CMN_SEED_INV] ?
		bifd_pkg::SEED_ONES : bifd_pkg::SEED_ZERO;
	assign final_crc = cmn_flags[bifd_pkg::CMN_RES_INV] ?
		~calc_crc : calc_crc;

	// Tag stepping; note the application polarity is the reverse.
	assign src_ref_inc = !src_flags[bifd_pkg::SRC_REF_FIXED];
	assign src_app_inc = src_flags[bifd_pkg::SRC_APP_INCR];
	assign dst_ref_inc = !dst_flags[bifd_pkg::DST_REF_FIXED];
	assign dst_app_inc = dst_flags[bifd_pkg::DST_APP_INCR];

	// All-ones escape detection on the source fields.
	assign app_ones = &src_app;
	assign ref_ones = &src_ref;
	assign grd_ones = &src_guard;
	assign fdet_ar = src_flags[bifd_pkg::SRC_AR_FDET] && app_ones &&
		ref_ones;
	assign fdet_app = src_flags[bifd_pkg::SRC_APP_FDET] && app_ones;
	assign fdet_all = src_flags[bifd_pkg::SRC_ALL_FDET] && app_ones &&
		ref_ones && grd_ones;
	assign fdet = fdet_ar || fdet_app || fdet_all;

	// Status code; any escape suppresses all three mismatch checks.
	always_comb begin
		next_status = 8'h00;
		if (!fdet) begin
			if (!src_flags[bifd_pkg::SRC_GRD_NOCHK] &&
				final_crc != src_guard) begin
				next_status = next_status | bifd_pkg::ST_GUARD;
			end
			if (src_app != exp_app) begin
				next_status = next_status | bifd_pkg::ST_APP;
			end
			if (!src_flags[bifd_pkg::SRC_REF_NOCHK] &&
				src_ref != exp_ref) begin
				next_status = next_status | bifd_pkg::ST_REF;
			end
		end
		// The error enable only counts with all-ones detect on.
		if (fdet_all && src_flags[bifd_pkg::SRC_ALL_ERR]) begin
			next_status = next_status | bifd_pkg::ST_ALLF;
		end
	end

	// Per-block result registers; one cycle after blk_valid.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			res_valid <= 1'h0;
			blk_status <= 8'h00;
		end else begin
			res_valid <= blk_valid;
			if (blk_valid) begin
				blk_status <= next_status;
			end
		end
	end

	// Destination fields; pass-through only honoured for update.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_guard <= 16'h0000;
			out_app <= 16'h0000;
			out_ref <= 32'h0000_0000;
		end else if (blk_valid) begin
			out_guard <= (is_update && dst_flags[bifd_pkg::DST_GRD_PASS]) ?
				src_guard : final_crc;
			out_app <= (is_update && dst_flags[bifd_pkg::DST_APP_PASS]) ?
				src_app : gen_app;
			out_ref <= (is_update && dst_flags[bifd_pkg::DST_REF_PASS]) ?
				src_ref : gen_ref;
		end
	end

	// Sticky status; a new error in the clearing cycle wins over the clear.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sticky_status <= 8'h00;
		end else begin
			sticky_status <= ((wr_en && paddr == bifd_pkg::A_STATUS) ?
				(sticky_status & ~pwdata[7:0]) : sticky_status) |
				(blk_valid ? next_status : 8'h00);
		end
	end

	// Last final CRC for software inspection.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			last_crc <= 16'h0000;
		end else if (blk_valid) begin
			last_crc <= final_crc;
		end
	end

	// Read mux; unmapped reads return zero with pslverr.
	always_comb begin
		prdata = 32'h0000_0000;
		if (rd_en) begin
			case (paddr)
				bifd_pkg::A_CTRL: prdata = {8'h00, src_flags, dst_flags, cmn_flags};
				bifd_pkg::A_OPER: prdata = {24'h000000, op_code};
				bifd_pkg::A_DECODE: prdata = {12'h000, src_ref_inc, src_app_inc,
					dst_ref_inc, dst_app_inc, crc_seed[0], 2'h0, blk_bytes};
				bifd_pkg::A_STATUS: prdata = {24'h000000, sticky_status};
				bifd_pkg::A_CRC: prdata = {16'h0000, last_crc};
				default: prdata = 32'h0000_0000;
			endcase
		end
	end

	// Named steps shared by the checks below; a block, then a bus write.
	sequence seq_block_taken;
		blk_valid;
	endsequence
	sequence seq_ctrl_write;
		psel && penable && pwrite && paddr == bifd_pkg::A_CTRL;
	endsequence
	// A block shows its result on the next cycle, and only then.
	chk_result_pulse: assert property (
		@(posedge pclk) disable iff (!presetn)
		seq_block_taken |=> res_valid)
		else $error("block result missing");
	chk_result_idle: assert property (
		@(posedge pclk) disable iff (!presetn)
		!blk_valid |=> !res_valid)
		else $error("result without a block");
	// Guard mismatch flagged only when checking is on and nothing escapes.
	chk_guard_code: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && !fdet && !src_flags[bifd_pkg::SRC_GRD_NOCHK] &&
		(final_crc != src_guard) |=> res_valid && blk_status[0])
		else $error("guard mismatch not reported");
	chk_ref_skip: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && src_flags[bifd_pkg::SRC_REF_NOCHK] |=>
		!blk_status[2])
		else $error("ref check not skipped");
	chk_escape_quiet: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && fdet |=> blk_status[2:0] == 3'h0)
		else $error("escape did not silence checks");
	chk_allf_gate: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && !src_flags[bifd_pkg::SRC_ALL_FDET] |=>
		!blk_status[3])
		else $error("all-ones error without detect");
	chk_allf_report: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && fdet_all && src_flags[bifd_pkg::SRC_ALL_ERR] |=>
		blk_status == bifd_pkg::ST_ALLF)
		else $error("all-ones error missing");
	// The kept CRC is complemented only on request; a slip here would
	// pass every guard check that uses the same wrong value.
	chk_crc_invert: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && cmn_flags[bifd_pkg::CMN_RES_INV] |=>
		last_crc == ~$past(calc_crc))
		else $error("final CRC not inverted");
	chk_crc_plain: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && !cmn_flags[bifd_pkg::CMN_RES_INV] |=>
		last_crc == $past(calc_crc))
		else $error("final CRC changed");
	// Seed value, and the seed taken from the byte just written.
	chk_seed_value: assert property (
		@(posedge pclk) disable iff (!presetn)
		crc_seed == (cmn_flags[2] ? 16'hFFFF : 16'h0000))
		else $error("wrong seed");
	chk_seed_write: assert property (
		@(posedge pclk) disable iff (!presetn)
		seq_ctrl_write |=> crc_seed == {16{$past(pwdata[2])}})
		else $error("seed not taken from write");
	// Every size code against its length; reserved bits play no part.
	chk_size_512: assert property (
		@(posedge pclk) disable iff (!presetn)
		cmn_flags[1:0] == 2'h0 |-> blk_bytes == 13'h0200)
		else $error("wrong 512 block size");
	chk_size_520: assert property (
		@(posedge pclk) disable iff (!presetn)
		cmn_flags[1:0] == 2'h1 |-> blk_bytes == 13'h0208)
		else $error("wrong 520 block size");
	chk_size_4096: assert property (
		@(posedge pclk) disable iff (!presetn)
		cmn_flags[1:0] == 2'h2 |-> blk_bytes == 13'h1000)
		else $error("wrong 4096 block size");
	chk_size_map: assert property (
		@(posedge pclk) disable iff (!presetn)
		cmn_flags[1:0] == 2'h3 |-> blk_bytes == 13'h1008)
		else $error("wrong block size");
	// Tag stepping follows the control byte just written.
	chk_ref_type: assert property (
		@(posedge pclk) disable iff (!presetn)
		seq_ctrl_write |=> src_ref_inc == !$past(pwdata[23]))
		else $error("source ref stepping wrong");
	chk_app_type: assert property (
		@(posedge pclk) disable iff (!presetn)
		seq_ctrl_write |=> src_app_inc == $past(pwdata[20]))
		else $error("source app stepping wrong");
	chk_dst_ref_type: assert property (
		@(posedge pclk) disable iff (!presetn)
		seq_ctrl_write |=> dst_ref_inc == !$past(pwdata[15]))
		else $error("dest ref stepping wrong");
	chk_dst_app_type: assert property (
		@(posedge pclk) disable iff (!presetn)
		seq_ctrl_write |=> dst_app_inc == $past(pwdata[12]))
		else $error("dest app stepping wrong");
	// Destination fields; the copy paths exist only for update.
	chk_guard_pass: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && !is_update |=> out_guard == $past(final_crc))
		else $error("pass-through used outside update");
	chk_guard_copy: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && is_update &&
		dst_flags[bifd_pkg::DST_GRD_PASS] |=>
		out_guard == $past(src_guard))
		else $error("guard not copied");
	chk_app_pass: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && is_update &&
		dst_flags[bifd_pkg::DST_APP_PASS] |=>
		out_app == $past(src_app))
		else $error("app tag not copied");
	chk_ref_pass: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid && is_update &&
		dst_flags[bifd_pkg::DST_REF_PASS] |=>
		out_ref == $past(src_ref))
		else $error("ref tag not copied");
	chk_ref_gen: assert property (
		@(posedge pclk) disable iff (!presetn)
		blk_valid &&
		!(is_update && dst_flags[bifd_pkg::DST_REF_PASS]) |=>
		out_ref == $past(gen_ref))
		else $error("ref tag not generated");
	// Every status bit of a block also lands in the sticky copy.
	chk_sticky_hold: assert property (
		@(posedge pclk) disable iff (!presetn)
		res_valid && blk_status != 8'h00 |->
		(sticky_status & blk_status) == blk_status)
		else $error("status not sticky");
endmodule : bifd_decode

/* File: bifd_dp_model.sv */
// Model of the datapath that hands block fields to the decoder.
`timescale 1ns/1ps
module bifd_dp_model (
	input wire logic pclk, // Engine clock.
	output logic blk_valid, // One block presented.
	output logic [15:0] src_guard, // Source guard.
	output logic [15:0] src_app, // Source application tag.
	output logic [31:0] src_ref, // Source reference tag.
	output logic [15:0] calc_crc, // Raw CRC of the block.
	output logic [15:0] exp_app, // Expected application tag.
	output logic [31:0] exp_ref, // Expected reference tag.
	output logic [15:0] gen_app, // Generated application tag.
	output logic [31:0] gen_ref // Generated reference tag.
);
	// Idle until the first block.
	initial begin
		blk_valid = 1'b0;
		{src_guard, src_app, src_ref, calc_crc} = '0;
		{exp_app, exp_ref, gen_app, gen_ref} = '0;
	end
	// One block for one cycle; the fields are then inverted, so that a
	// decoder sampling late sees wrong data rather than a kind leftover.
	task automatic send(input logic [175:0] f);
		@(posedge pclk);
		blk_valid <= 1'b1;
		{src_guard, src_app, src_ref, calc_crc, exp_app, exp_ref, gen_app,
			gen_ref} <= f;
		@(posedge pclk);
		blk_valid <= 1'b0;
		{src_guard, src_app, src_ref, calc_crc, exp_app, exp_ref, gen_app,
			gen_ref} <= ~f;
	endtask : send
endmodule : bifd_dp_model

/* File: bifd_decode_tb.sv */
// Self-checking bench of the block integrity field control decoder.
`timescale 1ns/1ps
`define CHK(n, e, s) begin \
	total_checks++; \
	if ((s) !== (e)) begin \
		n_fail++; \
		$display("mismatch %s exp %h got %h", n, e, s); \
	end \
end
module bifd_decode_tb;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic pready, pslverr, err, blk_valid, res_valid;
	logic src_ref_inc, src_app_inc, dst_ref_inc, dst_app_inc;
	logic [15:0] src_guard, src_app, calc_crc, exp_app, gen_app;
	logic [15:0] crc_seed, out_guard, out_app;
	logic [31:0] src_ref, exp_ref, gen_ref, out_ref;
	logic [12:0] blk_bytes;
	logic [7:0] blk_status;
	int n_fail = 0;
	int total_checks = 0;
	// Free-running engine clock.
	always #10 pclk = ~pclk;
	bifd_dp_model bifd_dp_model_inst (.pclk(pclk), .blk_valid(blk_valid),
		.src_guard(src_guard), .src_app(src_app), .src_ref(src_ref),
		.calc_crc(calc_crc), .exp_app(exp_app), .exp_ref(exp_ref),
		.gen_app(gen_app), .gen_ref(gen_ref));
	bifd_decode bifd_decode_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .blk_valid(blk_valid), .src_guard(src_guard),
		.src_app(src_app), .src_ref(src_ref), .calc_crc(calc_crc),
		.exp_app(exp_app), .exp_ref(exp_ref), .gen_app(gen_app),
		.gen_ref(gen_ref), .blk_bytes(blk_bytes), .crc_seed(crc_seed),
		.src_ref_inc(src_ref_inc), .src_app_inc(src_app_inc),
		.dst_ref_inc(dst_ref_inc), .dst_app_inc(dst_app_inc),
		.res_valid(res_valid), .blk_status(blk_status),
		.out_guard(out_guard), .out_app(out_app), .out_ref(out_ref));
	// One APB transfer; the request stands until pready is seen high.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// Program the three control bytes and the operation code.
	task automatic setc(input logic [7:0] cm, ds, sr, op);
		apb(1'b1, bifd_pkg::A_CTRL, {8'h00, sr, ds, cm});
		apb(1'b1, bifd_pkg::A_OPER, {24'h0, op});
	endtask : setc
	// Send one block and look at the result in the cycle it stands.
	task automatic blk(input logic [15:0] g, a, input logic [31:0] r,
		input logic [15:0] c, ea, input logic [31:0] er,
		input logic [15:0] ga, input logic [31:0] gr);
		bifd_dp_model_inst.send({g, a, r, c, ea, er, ga, gr});
		@(negedge pclk);
		`CHK("res_valid", 1'b1, res_valid)
		@(negedge pclk);
		`CHK("res_idle", 1'b0, res_valid)
	endtask : blk
	// Every size code, seed and tag type, reserved bits set to ones.
	task automatic t_decode();
		logic [12:0] sz[4] = '{bifd_pkg::BLK_512, bifd_pkg::BLK_520,
			bifd_pkg::BLK_4096, bifd_pkg::BLK_4104};
		logic [1:0] i;
		for (int k = 0; k < 4; k++) begin
			i = k[1:0];
			setc({5'h1E, i[0], i}, {i[0], 2'b0, i[1], 1'b0, 3'h7},
				{i[0], 2'b0, i[1], 4'h0}, bifd_pkg::OP_UPDATE);
			apb(1'b0, bifd_pkg::A_DECODE, 32'h0);
			`CHK("dec", {12'h0, ~i[0], i[1], ~i[0], i[1], i[0], 2'b0, sz[k]}, rd)
			`CHK("size", sz[k], blk_bytes)
			`CHK("seed", {16{i[0]}}, crc_seed)
			`CHK("rinc", ~i[0], src_ref_inc)
			`CHK("ainc", i[1], src_app_inc)
			`CHK("drinc", ~i[0], dst_ref_inc)
			`CHK("dainc", i[1], dst_app_inc)
		end
		$display("test decode done");
	endtask : t_decode
	// Guard with and without result inversion, disables, ORed codes.
	task automatic t_checks();
		setc(8'h08, 8'h00, 8'h00, bifd_pkg::OP_CHECK);
		blk(16'hEDCB, 16'h1, 32'h5, 16'h1234, 16'h2, 32'h6, 16'h0, 32'h0);
		`CHK("inv", 8'h06, blk_status)
		setc(8'h00, 8'h00, 8'h60, bifd_pkg::OP_CHECK);
		blk(16'hEDCB, 16'h2, 32'h5, 16'h1234, 16'h2, 32'h6, 16'h0, 32'h0);
		`CHK("dis", 8'h00, blk_status)
		setc(8'h00, 8'h00, 8'h00, bifd_pkg::OP_CHECK);
		blk(16'hEDCB, 16'h2, 32'h5, 16'h1234, 16'h2, 32'h6, 16'h0, 32'h0);
		`CHK("raw", 8'h05, blk_status)
		$display("test checks done");
	endtask : t_checks
	// All-ones escapes, taken and not taken.
	task automatic t_fdet();
		logic [7:0] fl[7] = '{8'h08, 8'h04, 8'h02, 8'h03, 8'h01, 8'h02, 8'h08};
		logic [1:0] kd[7] = '{2'h1, 2'h0, 2'h3, 2'h3, 2'h3, 2'h1, 2'h0};
		logic [7:0] ex[7] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h07, 8'h07, 8'h07};
		for (int i = 0; i < 7; i++) begin
			setc(8'h00, 8'h00, fl[i], bifd_pkg::OP_CHECK);
			blk({16{kd[i][1]}}, 16'hFFFF, kd[i][0] ? 32'hFFFFFFFF : 32'h1,
				16'h0001, 16'h0000, 32'h0, 16'h0, 32'h0);
			`CHK("fdet", ex[i], blk_status)
			`CHK("allf", ex[i][3], blk_status[3])
		end
		$display("test fdet done");
	endtask : t_fdet
	// Pass-through bits under each operation, then generation on update.
	task automatic t_pass();
		logic [7:0] op[4] = '{bifd_pkg::OP_CHECK, bifd_pkg::OP_INSERT,
			bifd_pkg::OP_STRIP, bifd_pkg::OP_UPDATE};
		logic pt;
		for (int i = 0; i < 5; i++) begin
			setc(8'h08, i < 4 ? 8'h68 : 8'h00, 8'h60, op[i < 4 ? i : 3]);
			blk(16'hA5A5, 16'h1111, 32'h22222222, 16'h00FF, 16'h1111, 32'h0,
				16'h3333, 32'h44444444);
			pt = (i == 3);
			`CHK("grd", pt ? 16'hA5A5 : 16'hFF00, out_guard)
			`CHK("app", pt ? 16'h1111 : 16'h3333, out_app)
			`CHK("ref", pt ? 32'h22222222 : 32'h44444444, out_ref)
		end
		$display("test pass done");
	endtask : t_pass
	// Sticky status, control readback and an unmapped address.
	task automatic t_regs();
		apb(1'b1, bifd_pkg::A_STATUS, 32'hFF);
		apb(1'b0, bifd_pkg::A_STATUS, 32'h0);
		`CHK("clr", 32'h0, rd)
		setc(8'h00, 8'h00, 8'h40, bifd_pkg::OP_CHECK);
		blk(16'h0002, 16'h0, 32'h0, 16'h0001, 16'h0, 32'h0, 16'h0, 32'h0);
		apb(1'b0, bifd_pkg::A_STATUS, 32'h0);
		`CHK("sts", 32'h1, rd)
		apb(1'b0, bifd_pkg::A_CRC, 32'h0);
		`CHK("crc", 32'h1, rd)
		`CHK("rdy", 1'b1, pready)
		apb(1'b0, bifd_pkg::A_CTRL, 32'h0);
		`CHK("ctrl", 32'h00400000, rd)
		apb(1'b0, 8'h40, 32'h0);
		`CHK("unmap", 1'b1, err)
		`CHK("unmap rd", 32'h0, rd)
		$display("test regs done");
	endtask : t_regs
	// Print the counts and the verdict, then stop.
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : wrap_up
	// Main sequence.
	initial begin
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_decode();
		t_checks();
		t_fdet();
		t_pass();
		t_regs();
		wrap_up();
	end
	// Watchdog; the tests need well under a thousand cycles.
	initial begin
		repeat (3000) @(posedge pclk);
		n_fail++;
		wrap_up();
	end
endmodule : bifd_decode_tb
